// ---- include/mcu_map_consts.vh ----
/*
 * Address map, register offsets, reset values and vector addresses of the
 * microcontroller address decoder.
 * Assumes it is included by bare name from design files that use the macros.
 */
// Operation
// - Decode a flat 64K byte space reached with 16-bit addresses.
// - Reserve 192 bytes of registers, up to 512 bytes RAM, 16K program memory.
// - Stack window is RAM addresses 0100h through 013Fh inclusive.
// - Reset and interrupt vectors sit in the topmost bytes, two bytes each.
// - USB, serial, two-wire, timer vector at FFF0h..FFF7h, masked, no halt exit.
// - Eight external pin interrupts share FFF8h, masked, may end halt.
// - USB end-of-suspend vectors at FFFAh, masked, may end halt.
// - Trap at FFFCh, reset at FFFEh, unmaskable; only reset ends halt.
// - Register decoder places ports, interrupt, misc, converter, watchdog, timer, serial.
// - Timer and alternate counters reset FFFCh; high bytes read-only, low writable.
// - Compare values reset 8000h; capture registers read-only, undefined at reset; the register file clears them to 00h.
// - Pins keep reset configuration while in reset, change only after release.
// - Two-wire clock and data pins only ever pull low, open drain.
// - Port A bits 5,4 are captures and interrupts 2,1; bit 3 timer clock.
// - Pending maskable interrupt held while mask set, taken when mask clears.
`ifndef MCU_MAP_CONSTS_VH
`define MCU_MAP_CONSTS_VH

// ---------------------------------------------------------------
// Address regions
// ---------------------------------------------------------------
`define REG_BASE        16'h0000
`define REG_LAST        16'h00BF
`define RAM_BASE        16'h00C0
`define RAM_LAST        16'h02BF
`define RAM_DEPTH       512
`define STACK_BASE      16'h0100
`define STACK_LAST      16'h013F
`define ROM_BASE        16'hC000
`define ROM_LAST        16'hFFFF
`define REG_COUNT       37
`define REG_LAST_IMPL   8'h24

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define OFF_PA_DATA     8'h00
`define OFF_PA_DIR      8'h01
`define OFF_PB_DATA     8'h02
`define OFF_PB_DIR      8'h03
`define OFF_PC_DATA     8'h04
`define OFF_PC_DIR      8'h05
`define OFF_RSV0_FIRST  8'h06
`define OFF_RSV0_LAST   8'h07
`define OFF_EXT_IRQ     8'h08
`define OFF_MISC        8'h09
`define OFF_ADC_RES     8'h0A
`define OFF_ADC_CS      8'h0B
`define OFF_WDOG        8'h0C
`define OFF_RSV1_FIRST  8'h0D
`define OFF_RSV1_LAST   8'h10
`define OFF_TIM_CTL2    8'h11
`define OFF_TIM_CTL1    8'h12
`define OFF_TIM_FLAGS   8'h13
`define OFF_CAP1_HI     8'h14
`define OFF_CAP1_LO     8'h15
`define OFF_CMP1_HI     8'h16
`define OFF_CMP1_LO     8'h17
`define OFF_CNT_HI      8'h18
`define OFF_CNT_LO      8'h19
`define OFF_ALT_HI      8'h1A
`define OFF_ALT_LO      8'h1B
`define OFF_CAP2_HI     8'h1C
`define OFF_CAP2_LO     8'h1D
`define OFF_CMP2_HI     8'h1E
`define OFF_CMP2_LO     8'h1F
`define OFF_SER_FLAGS   8'h20
`define OFF_SER_BUF     8'h21
`define OFF_SER_BAUD    8'h22
`define OFF_SER_CTL1    8'h23
`define OFF_SER_CTL2    8'h24

// ---------------------------------------------------------------
// Non-zero reset values
// ---------------------------------------------------------------
`define RST_PC          8'hF0
`define RST_MISC        8'hF0
`define RST_WDOG        8'h7F
`define RST_CNT_HI      8'hFF
`define RST_CNT_LO      8'hFC
`define RST_CMP_HI      8'h80
`define RST_SER_FLAGS   8'hC0

// ---------------------------------------------------------------
// Vectors and interrupt source indices
// ---------------------------------------------------------------
`define VEC_BASE        16'hFFF0
`define VEC_RESET       16'hFFFE
`define SRC_COUNT       7
`define SRC_EXT         4
`define SRC_RESUME      5
`define SRC_TRAP        6

`endif

// ---- hdl/region_decode.v ----
/*
 * Combinational decode of a 16-bit CPU address into one block select.
 * Assumes the address is stable for the cycle in which it is decoded.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mcu_map_consts.vh"

module region_decode (
	// Address in
	input  wire [15:0] addr,
	// Selects out
	output reg         hit_reg,
	output reg         hit_ram,
	output reg         hit_rom,
	output reg         hit_rsv,
	output wire        hit_stack
);

	// ---------------------------------------------------------------
	// Region decode
	// ---------------------------------------------------------------
	wire reg_gap;
	assign reg_gap   = (addr[7:0] >= `OFF_RSV0_FIRST && addr[7:0] <= `OFF_RSV0_LAST) ||
	                   (addr[7:0] >= `OFF_RSV1_FIRST && addr[7:0] <= `OFF_RSV1_LAST) ||
	                   (addr[7:0] > `REG_LAST_IMPL);
	assign hit_stack = (addr >= `STACK_BASE) && (addr <= `STACK_LAST);

	// Exactly one block select is high for every address
	always @* begin
		hit_reg = 1'b0;
		hit_ram = 1'b0;
		hit_rom = 1'b0;
		hit_rsv = 1'b0;
		if (addr <= `REG_LAST) begin
			hit_reg = ~reg_gap;
			hit_rsv = reg_gap;
		end else if (addr <= `RAM_LAST) begin
			hit_ram = 1'b1;
		end else if (addr >= `ROM_BASE) begin
			hit_rom = 1'b1;
		end else begin
			hit_rsv = 1'b1;
		end
	end

endmodule
`default_nettype wire

// ---- hdl/vector_select.v ----
/*
 * Priority pick of one pending interrupt source and its vector address.
 * Assumes pending bits combine latched state with this cycle's new events; higher index wins.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mcu_map_consts.vh"

module vector_select (
	// Pending sources and CPU mask
	input  wire [6:0]  pend,
	input  wire        imask,
	// Pick out
	output reg         take,
	output reg  [2:0]  idx,
	output wire [15:0] vec
);

	integer k;

	// Maskable sources wait while the mask is set, trap never does
	always @* begin
		take = 1'b0;
		idx  = 3'h0;
		for (k = 0; k < `SRC_TRAP; k = k + 1) begin
			if (pend[k] && !imask) begin
				take = 1'b1;
				idx  = k[2:0];
			end
		end
		if (pend[`SRC_TRAP]) begin
			take = 1'b1;
			idx  = 3'h6;
		end
	end

	// Two-byte entries from the base upward
	assign vec = `VEC_BASE + {12'h000, idx, 1'b0};

endmodule
`default_nettype wire

// ---- hdl/mcu_address_map.v ----
/*
 * Address decoder, peripheral register file, RAM, port pins and interrupt
 * vector sequencing of an 8-bit microcontroller.
 * Assumes the CPU holds addr/rd/wr for one cycle per access, program memory
 * data arrives combinationally on prog_rdata, and pin inputs are synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mcu_map_consts.vh"

module mcu_address_map (
	// Clock and reset
	input  wire        clk,
	input  wire        resetn,
	// CPU bus
	input  wire [15:0] addr,
	input  wire        rd,
	input  wire        wr,
	input  wire [7:0]  wdata,
	output reg  [7:0]  rdata_ff,
	output reg         sel_reg_ff,
	output reg         sel_ram_ff,
	output reg         sel_rom_ff,
	output reg         sel_rsv_ff,
	output reg         in_stack_ff,
	// Program memory data
	input  wire [7:0]  prog_rdata,
	// Interrupt sources and CPU state
	input  wire        irq_usb,
	input  wire        irq_serial,
	input  wire        irq_twi,
	input  wire        irq_timer,
	input  wire        irq_usb_resume,
	input  wire        trap_req,
	input  wire        cpu_imask,
	input  wire        cpu_halted,
	input  wire        vec_ack,
	output reg         vec_req_ff,
	output reg  [15:0] vec_addr_ff,
	output reg         halt_wake_ff,
	// Port pins
	input  wire [7:0]  pa_in,
	input  wire [7:0]  pb_in,
	input  wire [7:0]  pc_in,
	output reg  [7:0]  pa_out_ff,
	output reg  [7:0]  pa_oe_ff,
	output reg  [7:0]  pb_out_ff,
	output reg  [7:0]  pb_oe_ff,
	output reg  [7:0]  pc_out_ff,
	output reg  [7:0]  pc_oe_ff,
	// Alternate pin functions
	output reg         capture_pin_one_ff,
	output reg         capture_pin_two_ff,
	output reg         timer_ext_clock_pin_ff,
	output reg  [7:0]  ext_irq_ff
);

	// ---------------------------------------------------------------
	// Register reset values and write permission
	// ---------------------------------------------------------------
	function [7:0] reset_val;
		input integer i;
		begin
			case (i)
				`OFF_PC_DATA:   reset_val = `RST_PC;
				`OFF_PC_DIR:    reset_val = `RST_PC;
				`OFF_MISC:      reset_val = `RST_MISC;
				`OFF_WDOG:      reset_val = `RST_WDOG;
				`OFF_CNT_HI:    reset_val = `RST_CNT_HI;
				`OFF_CNT_LO:    reset_val = `RST_CNT_LO;
				`OFF_ALT_HI:    reset_val = `RST_CNT_HI;
				`OFF_ALT_LO:    reset_val = `RST_CNT_LO;
				`OFF_CMP1_HI:   reset_val = `RST_CMP_HI;
				`OFF_CMP2_HI:   reset_val = `RST_CMP_HI;
				`OFF_SER_FLAGS: reset_val = `RST_SER_FLAGS;
				default:        reset_val = 8'h00;
			endcase
		end
	endfunction

	function writable;
		input integer i;
		begin
			case (i)
				`OFF_ADC_RES, `OFF_TIM_FLAGS, `OFF_CAP1_HI, `OFF_CAP1_LO,
				`OFF_CNT_HI, `OFF_ALT_HI, `OFF_CAP2_HI, `OFF_CAP2_LO,
				`OFF_SER_FLAGS: writable = 1'b0;
				8'h06, 8'h07, 8'h0D, 8'h0E, 8'h0F, 8'h10: writable = 1'b0;
				default: writable = 1'b1;
			endcase
		end
	endfunction

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	wire        hit_reg;
	wire        hit_ram;
	wire        hit_rom;
	wire        hit_rsv;
	wire        hit_stack;
	wire [15:0] ram_off;
	wire [8:0]  ram_idx;
	wire [5:0]  reg_idx;

	region_decode u_decode (
		.addr      (addr),
		.hit_reg   (hit_reg),
		.hit_ram   (hit_ram),
		.hit_rom   (hit_rom),
		.hit_rsv   (hit_rsv),
		.hit_stack (hit_stack)
	);

	assign ram_off = addr - `RAM_BASE;
	assign ram_idx = ram_off[8:0]; // Window offset fits the 512 entries
	assign reg_idx = addr[5:0];

	// Selects and stack flag of the access, one cycle after it is presented
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sel_reg_ff  <= 1'b0;
			sel_ram_ff  <= 1'b0;
			sel_rom_ff  <= 1'b0;
			sel_rsv_ff  <= 1'b0;
			in_stack_ff <= 1'b0;
		end else begin
			sel_reg_ff  <= (rd | wr) & hit_reg;
			sel_ram_ff  <= (rd | wr) & hit_ram;
			sel_rom_ff  <= (rd | wr) & hit_rom;
			sel_rsv_ff  <= (rd | wr) & hit_rsv;
			in_stack_ff <= (rd | wr) & hit_stack;
		end
	end

	// ---------------------------------------------------------------
	// Capture pin edges
	// ---------------------------------------------------------------
	reg  [1:0]  cap_prev_ff;
	wire        cap1_rise;
	wire        cap2_rise;

	// Previous capture pin levels for edge detection
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cap_prev_ff <= 2'b00;
		end else begin
			cap_prev_ff <= {pa_in[5], pa_in[4]};
		end
	end

	assign cap1_rise = pa_in[4] & ~cap_prev_ff[0];
	assign cap2_rise = pa_in[5] & ~cap_prev_ff[1];

	// ---------------------------------------------------------------
	// Peripheral register file
	// ---------------------------------------------------------------
	reg  [8*`REG_COUNT-1:0] regs_ff;
	wire                    reg_wr;

	assign reg_wr = wr & hit_reg;

	// One byte per register; captures latch the counter on a pin rise
	genvar g;
	generate
		for (g = 0; g < `REG_COUNT; g = g + 1) begin : g_reg
			always @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					regs_ff[8*g +: 8] <= reset_val(g);
				end else if (g == `OFF_CAP1_HI && cap1_rise) begin
					regs_ff[8*g +: 8] <= regs_ff[8*`OFF_CNT_HI +: 8];
				end else if (g == `OFF_CAP1_LO && cap1_rise) begin
					regs_ff[8*g +: 8] <= regs_ff[8*`OFF_CNT_LO +: 8];
				end else if (g == `OFF_CAP2_HI && cap2_rise) begin
					regs_ff[8*g +: 8] <= regs_ff[8*`OFF_CNT_HI +: 8];
				end else if (g == `OFF_CAP2_LO && cap2_rise) begin
					regs_ff[8*g +: 8] <= regs_ff[8*`OFF_CNT_LO +: 8];
				end else if (reg_wr && reg_idx == g && writable(g)) begin
					regs_ff[8*g +: 8] <= wdata;
				end
			end
		end
	endgenerate

	wire [7:0] pa_data;
	wire [7:0] pa_dir;
	wire [7:0] pb_data;
	wire [7:0] pb_dir;
	wire [7:0] pc_data;
	wire [7:0] pc_dir;
	wire [7:0] ext_enable;

	assign pa_data    = regs_ff[8*`OFF_PA_DATA +: 8];
	assign pa_dir     = regs_ff[8*`OFF_PA_DIR +: 8];
	assign pb_data    = regs_ff[8*`OFF_PB_DATA +: 8];
	assign pb_dir     = regs_ff[8*`OFF_PB_DIR +: 8];
	assign pc_data    = regs_ff[8*`OFF_PC_DATA +: 8];
	assign pc_dir     = regs_ff[8*`OFF_PC_DIR +: 8];
	assign ext_enable = regs_ff[8*`OFF_EXT_IRQ +: 8];

	// ---------------------------------------------------------------
	// RAM
	// ---------------------------------------------------------------
	reg  [7:0] ram_mem [0:`RAM_DEPTH-1];

	// Byte writes into the RAM window, stack included
	always @(posedge clk) begin
		if (wr && hit_ram) begin
			ram_mem[ram_idx] <= wdata;
		end
	end

	// ---------------------------------------------------------------
	// Read data
	// ---------------------------------------------------------------
	reg  [7:0] nxt_rdata;

	// Port data reads show the pin for input bits, latch for output bits
	always @* begin
		nxt_rdata = 8'h00;
		if (hit_reg) begin
			case (reg_idx)
				6'h00:   nxt_rdata = (pa_data & pa_dir) | (pa_in & ~pa_dir);
				6'h02:   nxt_rdata = (pb_data & pb_dir) | (pb_in & ~pb_dir);
				6'h04:   nxt_rdata = (pc_data & pc_dir) | (pc_in & ~pc_dir);
				default: nxt_rdata = regs_ff[8*reg_idx +: 8];
			endcase
		end else if (hit_ram) begin
			nxt_rdata = ram_mem[ram_idx];
		end else if (hit_rom) begin
			nxt_rdata = prog_rdata;
		end
	end

	// Read data register, holds between reads
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_ff <= 8'h00;
		end else if (rd) begin
			rdata_ff <= nxt_rdata;
		end
	end

	// ---------------------------------------------------------------
	// Port pins and alternate functions
	// ---------------------------------------------------------------
	reg  [7:0] nxt_pa_out;
	reg  [7:0] nxt_pa_oe;

	// Two-wire pins never drive high: enable only when pulling low
	always @* begin
		nxt_pa_out    = pa_data;
		nxt_pa_oe     = pa_dir;
		nxt_pa_out[1] = 1'b0;
		nxt_pa_out[2] = 1'b0;
		nxt_pa_oe[1]  = pa_dir[1] & ~pa_data[1];
		nxt_pa_oe[2]  = pa_dir[2] & ~pa_data[2];
	end

	// Pins sit as inputs throughout reset and move only after release
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pa_out_ff <= 8'h00;
			pa_oe_ff  <= 8'h00;
			pb_out_ff <= 8'h00;
			pb_oe_ff  <= 8'h00;
			pc_out_ff <= 8'h00;
			pc_oe_ff  <= 8'h00;
		end else begin
			pa_out_ff <= nxt_pa_out;
			pa_oe_ff  <= nxt_pa_oe;
			pb_out_ff <= pb_data;
			pb_oe_ff  <= pb_dir;
			pc_out_ff <= pc_data;
			pc_oe_ff  <= pc_dir;
		end
	end

	// Alternate inputs routed from port pins; only the pin interrupts are gated by the enable mask
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			capture_pin_one_ff     <= 1'b0;
			capture_pin_two_ff     <= 1'b0;
			timer_ext_clock_pin_ff <= 1'b0;
			ext_irq_ff             <= 8'h00;
		end else begin
			capture_pin_one_ff     <= pa_in[4];
			capture_pin_two_ff     <= pa_in[5];
			timer_ext_clock_pin_ff <= pa_in[3];
			ext_irq_ff             <= {pb_in[7:4], pa_in[7:4]} & ext_enable;
		end
	end

	// ---------------------------------------------------------------
	// Interrupt pending and vector sequencing
	// ---------------------------------------------------------------
	reg  [6:0]  pend_ff;
	reg  [6:0]  nxt_pend;
	reg  [6:0]  src_set;
	reg  [2:0]  vec_idx_ff;
	reg         boot_ff;
	wire        take;
	wire [2:0]  take_idx;
	wire [15:0] take_vec;
	wire        acked;

	assign acked = vec_ack & vec_req_ff;

	// Sticky pending bits; a new event beats the clear of its own ack
	always @* begin
		src_set = {trap_req, irq_usb_resume, |ext_irq_ff, irq_timer, irq_twi, irq_serial, irq_usb};
		nxt_pend = pend_ff;
		if (acked && !boot_ff) begin
			nxt_pend[vec_idx_ff] = 1'b0;
		end
		nxt_pend = nxt_pend | src_set;
	end

	vector_select u_vsel (
		.pend  (nxt_pend),
		.imask (cpu_imask),
		.take  (take),
		.idx   (take_idx),
		.vec   (take_vec)
	);

	// Reset vector first after release, then the highest pending source
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pend_ff      <= 7'h00;
			boot_ff      <= 1'b1;
			vec_req_ff   <= 1'b0;
			vec_addr_ff  <= `VEC_RESET;
			vec_idx_ff   <= 3'h0;
			halt_wake_ff <= 1'b0;
		end else begin
			pend_ff <= nxt_pend;
			if (boot_ff) begin
				vec_req_ff  <= ~acked;
				vec_addr_ff <= `VEC_RESET;
				boot_ff     <= ~acked;
			end else begin
				vec_req_ff  <= take;
				vec_addr_ff <= take ? take_vec : vec_addr_ff;
				vec_idx_ff  <= take_idx;
			end
			// Only external pins and end-of-suspend end halt
			halt_wake_ff <= cpu_halted & (nxt_pend[`SRC_EXT] | nxt_pend[`SRC_RESUME]);
		end
	end

endmodule
`default_nettype wire

// ---- bench/map_monitor.sv ----
/*
 * Checker of the address map: block selects, stack flag, read data, vectors, pins.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module map_monitor (
	// Clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// CPU bus
	input wire logic [15:0] addr,
	input wire logic        rd,
	input wire logic        wr,
	input wire logic [7:0]  rdata_ff,
	input wire logic        sel_reg_ff,
	input wire logic        sel_ram_ff,
	input wire logic        sel_rom_ff,
	input wire logic        sel_rsv_ff,
	input wire logic        in_stack_ff,
	// Vectors, halt and pins
	input wire logic        cpu_halted,
	input wire logic        vec_req_ff,
	input wire logic [15:0] vec_addr_ff,
	input wire logic        halt_wake_ff,
	input wire logic [7:0]  pa_out_ff
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// -------------------------------------------------------
	// Bus answers
	// -------------------------------------------------------
	one_select_a: assert property ((rd | wr) |=> $onehot({sel_reg_ff, sel_ram_ff, sel_rom_ff, sel_rsv_ff}))
		else $error("access without exactly one block select");
	idle_select_a: assert property (!(rd | wr) |=> !(sel_reg_ff | sel_ram_ff | sel_rom_ff | sel_rsv_ff | in_stack_ff))
		else $error("select raised without an access");
	stack_window_a: assert property ((rd | wr) |=> in_stack_ff == ($past(addr) >= 16'h0100 && $past(addr) <= 16'h013F))
		else $error("stack flag does not match the stack window");
	reg_area_a: assert property (((rd | wr) && addr <= 16'h00BF) |=> (sel_reg_ff | sel_rsv_ff) &&
		sel_reg_ff == ($past(addr) <= 16'h0024 && !($past(addr) inside {[16'h0006:16'h0007], [16'h000D:16'h0010]})))
		else $error("register area access not selected as registers");
	rom_area_a: assert property (((rd | wr) && addr >= 16'hC000) |=> sel_rom_ff)
		else $error("program area access not selected as program memory");
	reserved_zero_a: assert property ((rd && addr == 16'h0006) |=> rdata_ff == 8'h00)
		else $error("reserved register read is not zero");
	read_hold_a: assert property (!rd |=> $stable(rdata_ff))
		else $error("read data changed without a read");
	// -------------------------------------------------------
	// Vectors and pins
	// -------------------------------------------------------
	vector_top_a: assert property (vec_req_ff |-> vec_addr_ff[15:4] == 12'hFFF && !vec_addr_ff[0])
		else $error("vector outside the top two-byte entries");
	wake_halted_a: assert property (halt_wake_ff |-> $past(cpu_halted))
		else $error("wake raised while not halted");
	open_drain_a: assert property (pa_out_ff[2:1] == 2'b00)
		else $error("two-wire pin driven high");
endmodule
`default_nettype wire

// ---- bench/cpu_side_model.sv ----
/*
 * CPU-side partner: supplies program bytes and acknowledges vector requests.
 * Assumes the bench enables acknowledges and chooses the answer delay.
 */
`timescale 1ns/1ps
`default_nettype none
module cpu_side_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// Bus and vector link
	input  wire logic [15:0] addr,
	input  wire logic        vec_req_ff,
	output logic      [7:0]  prog_rdata,
	output logic             vec_ack,
	// Bench control
	input  wire logic        ack_en,
	input  wire logic [3:0]  ack_delay
);
	logic       ack_ff;
	logic [3:0] wait_ff;
	// Program memory pattern, changes with every address bit
	assign prog_rdata = addr[7:0] ^ addr[15:8] ^ 8'h5A;
	assign vec_ack    = ack_ff;
	// One-cycle acknowledge after the chosen delay, only while a request stands
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ack_ff  <= 1'b0;
			wait_ff <= 4'h0;
		end else begin
			ack_ff <= 1'b0;
			if (vec_req_ff && ack_en && !ack_ff) begin
				if (wait_ff == ack_delay) begin
					ack_ff  <= 1'b1;
					wait_ff <= 4'h0;
				end else begin
					wait_ff <= wait_ff + 4'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- bench/mcu_address_map_bench.sv ----
/*
 * Self-checking bench of the address map: registers, regions, vectors, wake, pins.
 * Assumes the checker and the CPU-side model compile before this file.
 */
`timescale 1ns/1ps
`default_nettype none
module mcu_address_map_bench;
	// Design and partner signals
	logic        clk, resetn, rd, wr, irq_usb, irq_serial, irq_twi, irq_timer, irq_usb_resume, trap_req;
	logic        cpu_imask, cpu_halted, vec_ack, vec_req_ff, halt_wake_ff, ack_en, in_stack_ff;
	logic        sel_reg_ff, sel_ram_ff, sel_rom_ff, sel_rsv_ff;
	logic        capture_pin_one_ff, capture_pin_two_ff, timer_ext_clock_pin_ff;
	logic [15:0] addr, vec_addr_ff;
	logic [7:0]  wdata, rdata_ff, prog_rdata, pa_in, pb_in, pc_in, ext_irq_ff;
	logic [7:0]  pa_out_ff, pa_oe_ff, pb_out_ff, pb_oe_ff, pc_out_ff, pc_oe_ff;
	logic [3:0]  ack_delay;
	int          fails = 0, compares = 0, cycles = 0;

	mcu_address_map i_dut (.clk, .resetn, .addr, .rd, .wr, .wdata, .rdata_ff, .sel_reg_ff, .sel_ram_ff,
		.sel_rom_ff, .sel_rsv_ff, .in_stack_ff, .prog_rdata, .irq_usb, .irq_serial, .irq_twi, .irq_timer,
		.irq_usb_resume, .trap_req, .cpu_imask, .cpu_halted, .vec_ack, .vec_req_ff, .vec_addr_ff,
		.halt_wake_ff, .pa_in, .pb_in, .pc_in, .pa_out_ff, .pa_oe_ff, .pb_out_ff, .pb_oe_ff, .pc_out_ff,
		.pc_oe_ff, .capture_pin_one_ff, .capture_pin_two_ff, .timer_ext_clock_pin_ff, .ext_irq_ff);
	cpu_side_model i_cpu (.clk, .resetn, .addr, .vec_req_ff, .prog_rdata, .vec_ack, .ack_en, .ack_delay);

	// Clock and hang guard
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			fails = fails + 1;
			end_of_test();
		end
	end

	// -------------------------------------------------------
	// Shared tasks
	// -------------------------------------------------------
	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task bus_rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata_ff;
	endtask
	// One-cycle event on a source: 0..6 by vector index, 7 a port B pin interrupt
	task pulse(input int s);
		@(posedge clk);
		case (s)
			0: irq_usb <= 1'b1;
			1: irq_serial <= 1'b1;
			2: irq_twi <= 1'b1;
			3: irq_timer <= 1'b1;
			4: pa_in[4] <= 1'b1;
			5: irq_usb_resume <= 1'b1;
			6: trap_req <= 1'b1;
			default: pb_in[7] <= 1'b1;
		endcase
		@(posedge clk);
		{irq_usb, irq_serial, irq_twi, irq_timer, irq_usb_resume, trap_req} <= 6'h00;
		{pa_in[4], pb_in[7]} <= 2'b00;
	endtask
	// Wait for a request, check its vector, let the partner take it
	task take_vec(input logic [15:0] e);
		int n;
		n = 0;
		#1;
		while (vec_req_ff !== 1'b1 && n < 40) begin
			@(posedge clk);
			#1 n++;
		end
		chk({15'h0, vec_req_ff}, 16'h0001);
		chk(vec_addr_ff, e);
		ack_en = 1'b1;
		while (vec_ack !== 1'b1 && n < 80) begin
			@(posedge clk);
			#1 n++;
		end
		ack_en = 1'b0;
		@(posedge clk);
		#1;
	endtask
	task end_of_test();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// -------------------------------------------------------
	// Scenarios
	// -------------------------------------------------------
	task automatic t_reset();
		logic [15:0] tab [23] = '{16'h0000, 16'h0100, 16'h0200, 16'h0300, 16'h04F0, 16'h0800, 16'h09F0,
			16'h0A00, 16'h0B00, 16'h0C7F, 16'h1100, 16'h1200, 16'h1300, 16'h1680, 16'h1700, 16'h18FF,
			16'h19FC, 16'h1AFF, 16'h1BFC, 16'h1E80, 16'h1F00, 16'h20C0, 16'h2400};
		logic [7:0]  d;
		take_vec(16'hFFFE);
		foreach (tab[i]) begin
			bus_rd({8'h00, tab[i][15:8]}, d);
			chk({8'h00, d}, {8'h00, tab[i][7:0]});
		end
		chk({pc_out_ff, pc_oe_ff}, 16'hF0F0);
		$display("test reset values done");
	endtask
	task automatic t_access();
		logic [23:0] tab [9] = '{24'h191212, 24'h1800FF, 24'h1A00FF, 24'h13FF00, 24'h0A5500, 24'h165555,
			24'h06AA00, 24'h0C3C3C, 24'h1F0101};
		logic [7:0]  d;
		foreach (tab[i]) begin
			wr_reg({8'h00, tab[i][23:16]}, tab[i][15:8]);
			bus_rd({8'h00, tab[i][23:16]}, d);
			chk({8'h00, d}, {8'h00, tab[i][7:0]});
		end
		$display("test register access done");
	endtask
	task automatic t_regions();
		logic [23:0] tab [11] = '{24'h000010, 24'h00BF02, 24'h00C008, 24'h010009, 24'h013F09, 24'h014008,
			24'h02BF08, 24'h02C002, 24'hBFFF02, 24'hC00004, 24'hFFFF04};
		logic [7:0]  d, e;
		foreach (tab[i]) begin
			wr_reg(tab[i][23:8], ~tab[i][15:8]);
			bus_rd(tab[i][23:8], d);
			chk({11'h0, sel_reg_ff, sel_ram_ff, sel_rom_ff, sel_rsv_ff, in_stack_ff}, {8'h0, tab[i][7:0]});
			e = tab[i][3] ? ~tab[i][15:8] : (tab[i][2] ? tab[i][15:8] ^ tab[i][23:16] ^ 8'h5A : 8'h00);
			if (!tab[i][4]) chk({8'h00, d}, {8'h00, e});
		end
		$display("test regions done");
	endtask
	task t_vectors();
		wr_reg(16'h0008, 8'hFF);
		for (int s = 0; s < 8; s++) begin
			ack_delay = s[3:0];
			pulse(s);
			take_vec(s == 7 ? 16'hFFF8 : 16'hFFF0 + 16'(s * 2));
			chk({15'h0, vec_req_ff}, 16'h0000);
		end
		$display("test vectors done");
	endtask
	task t_mask();
		@(posedge clk);
		cpu_imask <= 1'b1;
		pulse(3);
		repeat (8) @(posedge clk);
		#1 chk({15'h0, vec_req_ff}, 16'h0000);
		pulse(6);
		take_vec(16'hFFFC);
		@(posedge clk);
		cpu_imask <= 1'b0;
		take_vec(16'hFFF6);
		$display("test mask done");
	endtask
	task t_wake();
		@(posedge clk);
		{cpu_imask, cpu_halted} <= 2'b11;
		pulse(3);
		repeat (3) @(posedge clk);
		#1 chk({15'h0, halt_wake_ff}, 16'h0000);
		pulse(5);
		repeat (3) @(posedge clk);
		#1 chk({15'h0, halt_wake_ff}, 16'h0001);
		@(posedge clk);
		cpu_imask <= 1'b0;
		take_vec(16'hFFFA);
		@(posedge clk);
		#1 chk({15'h0, halt_wake_ff}, 16'h0000);
		take_vec(16'hFFF6);
		@(posedge clk);
		cpu_halted <= 1'b0;
		$display("test halt wake done");
	endtask
	task automatic t_pins();
		logic [15:0] tab [4] = '{16'h14FF, 16'h1512, 16'h1CFF, 16'h1D12};
		logic [7:0]  d;
		wr_reg(16'h0001, 8'hFF);
		wr_reg(16'h0000, 8'hFF);
		repeat (2) @(posedge clk);
		#1 chk({pa_out_ff, pa_oe_ff}, 16'hF9F9);
		wr_reg(16'h0000, 8'h00);
		repeat (2) @(posedge clk);
		#1 chk({pa_out_ff, pa_oe_ff}, 16'h00FF);
		@(posedge clk);
		pa_in <= 8'h38;
		@(posedge clk);
		#1 chk({13'h0, capture_pin_one_ff, capture_pin_two_ff, timer_ext_clock_pin_ff}, 16'h0007);
		chk({8'h00, ext_irq_ff}, 16'h0003);
		foreach (tab[i]) begin
			bus_rd({8'h00, tab[i][15:8]}, d);
			chk({8'h00, d}, {8'h00, tab[i][7:0]});
		end
		$display("test pins done");
	endtask

	// Main sequence
	initial begin
		{clk, resetn, rd, wr, irq_usb, irq_serial, irq_twi, irq_timer, irq_usb_resume, trap_req} = '0;
		{cpu_imask, cpu_halted, ack_en, ack_delay, addr, wdata, pa_in, pb_in, pc_in} = '0;
		repeat (10) @(posedge clk);
		#1 chk({pa_oe_ff, pb_oe_ff}, 16'h0000);
		chk({pc_oe_ff, 7'h00, vec_req_ff}, 16'h0000);
		chk({pb_out_ff, pc_out_ff}, 16'h0000);
		@(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_access();
		t_regions();
		t_vectors();
		t_mask();
		t_wake();
		t_pins();
		end_of_test();
	end
endmodule

bind mcu_address_map map_monitor i_mon (.clk, .resetn, .addr, .rd, .wr, .rdata_ff, .sel_reg_ff, .sel_ram_ff,
	.sel_rom_ff, .sel_rsv_ff, .in_stack_ff, .cpu_halted, .vec_req_ff, .vec_addr_ff, .halt_wake_ff, .pa_out_ff);
`default_nettype wire
